// [hw/pdf_top.sv]
// Pin D configuration register, pad control and modem routing
`timescale 1ns/1ns
`default_nettype none
`include "pdf_consts.svh"

module pdf_top
#(
  parameter int ADDR_W = `PDF_ADDR_W
)
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire pdf_pkg::pdf_word_t reg_wdata,
  output pdf_pkg::pdf_word_t     reg_rdata,
  input  wire logic              pin_in,
  output logic                   pin_out,
  output logic                   pin_oe,
  output logic                   pin_ibuf_on,
  output logic                   pin_pulldown_on,
  input  wire logic              modem_rts,
  input  wire logic              modem_carrier_detect,
  input  wire logic [2:0]        other_pins_uart_sel,
  output logic                   modem_rts_ctl,
  output logic                   uart_on_pins,
  output logic                   serial_uart_off
);
  import pdf_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  initial
  begin
    if (ADDR_W < 6 || ADDR_W > 16)
    begin
      $error("pdf_top ADDR_W must lie between 6 and 16");
    end
    if (`PDF_SYNC_STAGES < 2)
    begin
      $error("pdf_top needs at least two synchroniser stages");
    end
    // The register struct and the reset cast rely on this packing
    if (`PDF_FN_LSB != 0 || `PDF_PD_BIT != `PDF_FN_MSB + 1 || `PDF_OUT_BIT != `PDF_PD_BIT + 1)
    begin
      $error("pdf_top field positions do not match the register struct");
    end
    if (`PDF_IN_BIT != `PDF_OUT_BIT + 1 || `PDF_RSVD_LSB != `PDF_IN_BIT + 1)
    begin
      $error("pdf_top input level bit must sit between output level and reserved field");
    end
    if (`PDF_RSVD_MSB != `PDF_REG_W - 1)
    begin
      $error("pdf_top reserved field must reach the top of the word");
    end
    if ((`PDF_CFG_RESET >> `PDF_RSVD_LSB) != 0)
    begin
      $error("pdf_top reset value must keep the reserved bits clear");
    end
  end

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_chain;
  logic [1:0] next_rst_chain;
  logic       rst_n;

  always_comb
  begin
    next_rst_chain = {rst_chain[0], 1'b1};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_chain <= 2'h0;
    end
    else
    begin
      rst_chain <= next_rst_chain;
    end
  end

  // Every flop but the reset chain leaves reset on the same edge, two cycles after the pin rises
  assign rst_n = rst_chain[1];

  // ****************************************************************
  // Pin input synchroniser
  // ****************************************************************
  logic pin_sync;

  pdf_sync
  #(
    .STAGES (`PDF_SYNC_STAGES)
  )
  u_pin_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pin_in),
    .q     (pin_sync)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Only the pin D word is mapped; every other offset reads as zero
  function automatic logic hits_cfg(input logic [ADDR_W-1:0] a);
    hits_cfg = (a == ADDR_W'(`PDF_CFG_OFFSET));
  endfunction

  logic cfg_wr;
  logic cfg_rd;

  assign cfg_wr = reg_wr && hits_cfg(reg_addr);
  assign cfg_rd = reg_rd && hits_cfg(reg_addr);

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  pdf_cfg_t cfg;
  pdf_cfg_t next_cfg;

  always_comb
  begin
    next_cfg = cfg;
    if (cfg_wr)
    begin
      // Reserved bits and the input level bit are not stored
      next_cfg.fn          = pdf_fn_t'(reg_wdata[`PDF_FN_MSB:`PDF_FN_LSB]);
      next_cfg.pulldown_on = reg_wdata[`PDF_PD_BIT];
      next_cfg.out_level   = reg_wdata[`PDF_OUT_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg <= pdf_cfg_t'(5'(`PDF_CFG_RESET));
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  // ****************************************************************
  // Function decode
  // ****************************************************************
  pdf_pin_if pin_bus ();

  assign pin_bus.fn        = cfg.fn;
  assign pin_bus.out_level = cfg.out_level;
  assign pin_bus.rts_level = modem_rts;
  assign pin_bus.cd_level  = modem_carrier_detect;

  pdf_pin_pad u_pad
  (
    .p (pin_bus.pad)
  );

  // ****************************************************************
  // Live input level
  // ****************************************************************
  logic in_level;

  // The synchronised level trails the pad by two cycles
  // A disabled input buffer presents a low level
  assign in_level = pin_bus.ibuf_on & pin_sync;

  // ****************************************************************
  // Modem routing
  // ****************************************************************
  logic all_pins_uart;

  assign all_pins_uart = (cfg.fn == FN_RTS_IN) && (other_pins_uart_sel == 3'h7);

  // ****************************************************************
  // Registered pad outputs
  // ****************************************************************
  logic pad_oe;
  logic pad_out;
  logic pad_ibuf;
  logic pad_pd;
  logic next_pad_oe;
  logic next_pad_out;
  logic next_pad_ibuf;
  logic next_pad_pd;

  // Registered so the pad never sees decoder glitches while the function changes
  always_comb
  begin
    next_pad_oe   = pin_bus.drive_oe;
    next_pad_out  = pin_bus.drive_oe & pin_bus.drive_level;
    next_pad_ibuf = pin_bus.ibuf_on;
    next_pad_pd   = cfg.pulldown_on;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_oe   <= 1'b0;
      pad_out  <= 1'b0;
      pad_ibuf <= 1'b0;
      pad_pd   <= 1'b1;
    end
    else
    begin
      pad_oe   <= next_pad_oe;
      pad_out  <= next_pad_out;
      pad_ibuf <= next_pad_ibuf;
      pad_pd   <= next_pad_pd;
    end
  end

  // ****************************************************************
  // Registered modem outputs
  // ****************************************************************
  logic rts_ctl;
  logic pins_uart;
  logic next_rts_ctl;
  logic next_pins_uart;

  // Every code but 101 holds the modem request low
  always_comb
  begin
    next_rts_ctl   = pin_bus.rts_from_pin & pin_sync;
    next_pins_uart = all_pins_uart;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rts_ctl   <= 1'b0;
      pins_uart <= 1'b0;
    end
    else
    begin
      rts_ctl   <= next_rts_ctl;
      pins_uart <= next_pins_uart;
    end
  end

  assign pin_oe          = pad_oe;
  assign pin_out         = pad_out;
  assign pin_ibuf_on     = pad_ibuf;
  assign pin_pulldown_on = pad_pd;
  assign modem_rts_ctl   = rts_ctl;
  assign uart_on_pins    = pins_uart;
  assign serial_uart_off = pins_uart;

  // ****************************************************************
  // Read data
  // ****************************************************************
  pdf_word_t rdata;
  pdf_word_t next_rdata;

  function automatic pdf_word_t cfg_word(input pdf_cfg_t c, input logic lvl);
    pdf_word_t w;
    w = '0;
    w[`PDF_FN_MSB:`PDF_FN_LSB] = c.fn;
    w[`PDF_PD_BIT]             = c.pulldown_on;
    w[`PDF_OUT_BIT]            = c.out_level;
    w[`PDF_IN_BIT]             = lvl;
    w[`PDF_RSVD_MSB:`PDF_RSVD_LSB] = '0;
    cfg_word = w;
  endfunction

  // A read in the cycle of a write returns the word from before the write
  always_comb
  begin
    next_rdata = rdata;
    if (reg_rd)
    begin
      next_rdata = cfg_rd ? cfg_word(cfg, in_level) : `PDF_UNMAPPED_DATA;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata = rdata;

endmodule

`default_nettype wire

// [hw/pdf_consts.svh]
// Offsets, field positions, reset values and function codes of the pin D configuration block
`ifndef PDF_CONSTS_SVH
`define PDF_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PDF_CFG_OFFSET    8'h38
`define PDF_CFG_RESET     16'h0008
`define PDF_REG_W         16
`define PDF_UNMAPPED_DATA 16'h0000

// ****************************************************************
// Field positions
// ****************************************************************
`define PDF_FN_LSB        0
`define PDF_FN_MSB        2
`define PDF_PD_BIT        3
`define PDF_OUT_BIT       4
`define PDF_IN_BIT        5
`define PDF_RSVD_LSB      6
`define PDF_RSVD_MSB      15

// ****************************************************************
// Function codes
// ****************************************************************
`define PDF_FN_HIZ        3'h0
`define PDF_FN_OUT        3'h1
`define PDF_FN_OUT_RB     3'h2
`define PDF_FN_IN         3'h3
`define PDF_FN_OFF        3'h4
`define PDF_FN_RTS_IN     3'h5
`define PDF_FN_RTS_MON    3'h6
`define PDF_FN_CD_OUT     3'h7

// ****************************************************************
// Synchroniser and defaults
// ****************************************************************
`define PDF_SYNC_STAGES   2
`define PDF_ADDR_W        8

`endif

// [hw/pdf_pkg.sv]
// Types shared by the pin D configuration block
`include "pdf_consts.svh"

package pdf_pkg;

  typedef enum logic [`PDF_FN_MSB:`PDF_FN_LSB]
  {
    FN_HIZ     = `PDF_FN_HIZ,
    FN_OUT     = `PDF_FN_OUT,
    FN_OUT_RB  = `PDF_FN_OUT_RB,
    FN_IN      = `PDF_FN_IN,
    FN_OFF     = `PDF_FN_OFF,
    FN_RTS_IN  = `PDF_FN_RTS_IN,
    FN_RTS_MON = `PDF_FN_RTS_MON,
    FN_CD_OUT  = `PDF_FN_CD_OUT
  } pdf_fn_t;

  typedef struct packed
  {
    logic    out_level;
    logic    pulldown_on;
    pdf_fn_t fn;
  } pdf_cfg_t;

  typedef logic [`PDF_REG_W-1:0] pdf_word_t;

endpackage

// [hw/pdf_pin_if.sv]
// Signals between the register logic and the pad decoder
`timescale 1ns/1ns
`default_nettype none

interface pdf_pin_if;
  import pdf_pkg::*;

  pdf_fn_t fn;
  logic    out_level;
  logic    rts_level;
  logic    cd_level;
  logic    drive_oe;
  logic    drive_level;
  logic    ibuf_on;
  logic    rts_from_pin;

  modport ctl
  (
    output fn,
    output out_level,
    output rts_level,
    output cd_level,
    input  drive_oe,
    input  drive_level,
    input  ibuf_on,
    input  rts_from_pin
  );

  modport pad
  (
    input  fn,
    input  out_level,
    input  rts_level,
    input  cd_level,
    output drive_oe,
    output drive_level,
    output ibuf_on,
    output rts_from_pin
  );

endinterface

`default_nettype wire

// [hw/pdf_sync.sv]
// Multi-stage synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
`include "pdf_consts.svh"

module pdf_sync
#(
  parameter int STAGES = `PDF_SYNC_STAGES
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic [STAGES-1:0] chain;
  logic [STAGES-1:0] next_chain;

  initial
  begin
    if (STAGES < 2)
    begin
      $error("pdf_sync needs at least two stages");
    end
  end

  // Only the next stage reads each flop of the chain but the last, which drives q
  always_comb
  begin
    next_chain = {chain[STAGES-2:0], d};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chain <= '0;
    end
    else
    begin
      chain <= next_chain;
    end
  end

  assign q = chain[STAGES-1];

endmodule

`default_nettype wire

// [hw/pdf_pin_pad.sv]
// Function decoder: driver enable, driven level and input buffer enable of the pin
`timescale 1ns/1ns
`default_nettype none

module pdf_pin_pad
(
  pdf_pin_if.pad p
);
  import pdf_pkg::*;

  always_comb
  begin
    p.drive_oe     = 1'b0;
    p.drive_level  = 1'b0;
    p.ibuf_on      = 1'b0;
    p.rts_from_pin = 1'b0;
    case (p.fn)
      FN_HIZ:
      begin
        p.drive_oe = 1'b0;
      end
      FN_OUT:
      begin
        p.drive_oe    = 1'b1;
        p.drive_level = p.out_level;
      end
      FN_OUT_RB:
      begin
        p.drive_oe    = 1'b1;
        p.drive_level = p.out_level;
        p.ibuf_on     = 1'b1;
      end
      FN_IN:
      begin
        p.ibuf_on = 1'b1;
      end
      FN_OFF:
      begin
        p.drive_oe = 1'b0;
      end
      FN_RTS_IN:
      begin
        p.ibuf_on      = 1'b1;
        p.rts_from_pin = 1'b1;
      end
      FN_RTS_MON:
      begin
        p.drive_oe    = 1'b1;
        p.drive_level = p.rts_level;
      end
      FN_CD_OUT:
      begin
        p.drive_oe    = 1'b1;
        p.drive_level = p.cd_level;
        p.ibuf_on     = 1'b1;
      end
      default:
      begin
        p.drive_oe = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// [verif/pdf_monitor.sv]
// Port checker for the pin D configuration block
`timescale 1ns/1ns
`default_nettype none
`include "pdf_consts.svh"
module pdf_monitor
#(
  parameter int ADDR_W = `PDF_ADDR_W
)
(
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic [ADDR_W-1:0]  reg_addr,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire pdf_pkg::pdf_word_t reg_wdata,
  input wire pdf_pkg::pdf_word_t reg_rdata,
  input wire logic               pin_in,
  input wire logic               pin_out,
  input wire logic               pin_oe,
  input wire logic               pin_ibuf_on,
  input wire logic               pin_pulldown_on,
  input wire logic               modem_rts,
  input wire logic               modem_carrier_detect,
  input wire logic [2:0]         other_pins_uart_sel,
  input wire logic               modem_rts_ctl,
  input wire logic               uart_on_pins,
  input wire logic               serial_uart_off
);
  import pdf_pkg::*;
  logic [4:0] cfg;
  logic [4:0] next_cfg;
  logic       hit;
  logic       drv;
  logic       ibuf;
  logic       lvl;
  assign hit  = reg_addr == ADDR_W'(`PDF_CFG_OFFSET);
  assign drv  = cfg[2:0] inside {3'h1, 3'h2, 3'h6, 3'h7};
  assign ibuf = cfg[2:0] inside {3'h2, 3'h3, 3'h5, 3'h7};
  assign lvl  = cfg[2:0] == 3'h6 ? modem_rts : cfg[2:0] == 3'h7 ? modem_carrier_detect : drv & cfg[4];
  always_comb
  begin
    next_cfg = cfg;
    if (reg_wr && hit)
      next_cfg = reg_wdata[4:0];
  end
  // Shadow of the writable fields
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      cfg <= 5'h08;
    else
      cfg <= next_cfg;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  driver_enable_a: assert property (pin_oe == $past(drv)) else $error("driver enable wrong");
  drive_level_a: assert property (pin_out == $past(lvl)) else $error("driven level wrong");
  input_buffer_a: assert property (pin_ibuf_on == $past(ibuf)) else $error("input buffer wrong");
  pulldown_follow_a: assert property (pin_pulldown_on == $past(cfg[3])) else $error("pull-down wrong");
  uart_route_a: assert property (uart_on_pins == $past(cfg[2:0] == 3'h5 && other_pins_uart_sel == 3'h7))
    else $error("modem routing wrong");
  serial_cut_a: assert property (serial_uart_off == $past(cfg[2:0] == 3'h5 && other_pins_uart_sel == 3'h7))
    else $error("serial path wrong");
  read_mask_a: assert property (reg_rd && hit |=> reg_rdata[15:6] == 10'h0 && reg_rdata[4:0] == $past(cfg)
    && ($past(ibuf) || !reg_rdata[5])) else $error("read word wrong");
  unmapped_read_a: assert property (reg_rd && !hit |=> reg_rdata == 16'h0000) else $error("unmapped read");
  rts_follow_a: assert property ((cfg[2:0] == 3'h5 && $stable(pin_in)) [*4]
    |=> modem_rts_ctl == $past(pin_in)) else $error("rts control wrong");
endmodule
bind pdf_top pdf_monitor #(.ADDR_W(ADDR_W)) mon (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .pin_in, .pin_out, .pin_oe, .pin_ibuf_on, .pin_pulldown_on, .modem_rts, .modem_carrier_detect,
  .other_pins_uart_sel, .modem_rts_ctl, .uart_on_pins, .serial_uart_off);
`default_nettype wire

// [verif/pdf_far_end.sv]
// Far party on the pin and the resolved wire level
`timescale 1ns/1ns
`default_nettype none
module pdf_far_end
(
  input  wire logic clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic pin_pulldown_on,
  input  wire logic drv_en,
  input  wire logic drv_level,
  output logic      line
);
  logic last = 1'b0;
  always_ff @(posedge clk)
    last <= line;
  // Floating without pull-down flips each cycle
  always_comb
    if (pin_oe)
      line = pin_out;
    else if (drv_en)
      line = drv_level;
    else if (pin_pulldown_on)
      line = 1'b0;
    else
      line = ~last;
endmodule
`default_nettype wire

// [verif/pin_d_function_config_tb.sv]
// Self-checking bench for the pin D configuration block
`timescale 1ns/1ns
`default_nettype none
module pin_d_function_config_tb;
  import pdf_pkg::*;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  pdf_word_t  reg_wdata = 16'h0000;
  pdf_word_t  reg_rdata;
  logic       pin_line;
  logic       pin_out, pin_oe, pin_ibuf_on, pin_pulldown_on, modem_rts_ctl, uart_on_pins, serial_uart_off;
  logic       modem_rts = 1'b0, modem_carrier_detect = 1'b0, drv_en = 1'b0, drv_level = 1'b0;
  logic [2:0] other_pins_uart_sel = 3'h0;
  int         err_count = 0, samples_checked = 0;

  always #4 clk = ~clk;

  pdf_top uut (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pin_in(pin_line),
    .pin_out, .pin_oe, .pin_ibuf_on, .pin_pulldown_on, .modem_rts, .modem_carrier_detect,
    .other_pins_uart_sel, .modem_rts_ctl, .uart_on_pins, .serial_uart_off);
  pdf_far_end far (.clk, .pin_out, .pin_oe, .pin_pulldown_on, .drv_en, .drv_level, .line(pin_line));

  function automatic logic drives(input logic [2:0] f);
    return f inside {3'h1, 3'h2, 3'h6, 3'h7};
  endfunction
  function automatic logic buffered(input logic [2:0] f);
    return f inside {3'h2, 3'h3, 3'h5, 3'h7};
  endfunction
  function automatic logic line_of(input pdf_word_t c);
    case (c[2:0])
      3'h1, 3'h2: return c[4];
      3'h6: return modem_rts;
      3'h7: return modem_carrier_detect;
      default: return drv_en & drv_level;
    endcase
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input pdf_word_t d);
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(input int n);
    resetn = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({pin_oe, pin_out, pin_ibuf_on, pin_pulldown_on}, 16'h1);
    bus(0, 1, 8'h38, 0);
    chk(reg_rdata, 16'h0008);
  endtask

  initial
  begin
    #100000;
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    pdf_word_t d;
    logic      ln;
    void'($urandom(94168));
    do_reset(6);
    // Every function code three times, modem routing forced in the middle pass
    for (int i = 0; i < 24; i++)
    begin
      d = 16'($urandom);
      d[2:0] = 3'(i);
      other_pins_uart_sel = (i / 8 == 1) ? 3'h7 : 3'($urandom);
      modem_rts = 1'($urandom);
      modem_carrier_detect = 1'($urandom);
      drv_level = 1'($urandom);
      drv_en = 1'($urandom) | ~d[3];
      bus(1, 0, 8'h38, d);
      repeat (4) @(posedge clk);
      #1;
      ln = line_of(d);
      chk({pin_oe, pin_out, pin_ibuf_on, pin_pulldown_on},
        {drives(d[2:0]), drives(d[2:0]) & ln, buffered(d[2:0]), d[3]});
      chk({modem_rts_ctl, uart_on_pins, serial_uart_off},
        {d[2:0] == 3'h5 && ln, {2{d[2:0] == 3'h5 && other_pins_uart_sel == 3'h7}}});
      bus(0, 1, 8'h38, 0);
      chk(reg_rdata, {10'h0, buffered(d[2:0]) & ln, d[4:0]});
    end
    bus(1, 0, 8'h39, 16'hffff);
    bus(0, 1, 8'h39, 0);
    chk(reg_rdata, 16'h0000);
    bus(1, 1, 8'h38, 16'h0001);
    chk(reg_rdata, {10'h0, buffered(d[2:0]) & ln, d[4:0]});
    bus(0, 1, 8'h38, 0);
    chk(reg_rdata, 16'h0001);
    do_reset(2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
